// *** rtl/cem_regs.sv ***
// Event flags, interrupt masks, converter control and current result registers
// Operation
// (RQ1) Charge phase change sets flag B bit3
// (RQ2) Input supply change sets flag B bit0
// (RQ3) Input overvoltage or sleep sets fault bit7
// (RQ4) Battery overcurrent or overvoltage sets fault bit6
// (RQ5) System rail fault sets fault bit5
// (RQ6) Thermal shutdown rising edge sets fault bit3
// (RQ7) Thermistor zone change sets fault bit0
// (RQ8) Done mask blocks one-shot completion pulse
// (RQ9) Masks block thermal and voltage regulation
// (RQ10) Min-system mask blocks entry and exit
// (RQ11) Input current mask blocks both limits
// (RQ12) Masks block safety and watchdog timers
// (RQ13) Mask B blocks phase and supply changes
// (RQ14) Fault mask bits 7..5 block faults
// (RQ15) Fault mask bits 3,0 block shutdown, zone
// (RQ16) Resets clear configuration; watchdog clears enable (both resets load the control register with 0x30, not zero)
// (RQ17) Results start zero, keep last measurement
// (RQ18) Rate bit: continuous or one-shot
// (RQ19) Sample field picks 12 to 9 bits
// (RQ20) Averaging enable and seed select
// (RQ21) Channel off bits exclude channels
// (RQ22) Input current signed, 2mA, clamped
// (RQ23) Battery current signed, polarity flip aborts
// (RQ24) Done status zero in continuous mode
// (RQ25) Unmasked new flag gives one low pulse
// (RQ26) Flags latch until read clears them
`timescale 1ns/1ns
module cem_regs
	import cem_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RESET,
	input  wire logic        REG_RESET,
	input  wire logic        WDOG_EXPIRED,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [7:0]  REG_WDATA,
	output logic      [7:0]  REG_RDATA,
	input  wire logic [1:0]  CHARGE_PHASE,
	input  wire logic [2:0]  INPUT_SUPPLY_STATUS,
	input  wire logic        INPUT_OVERVOLT_SLEEP,
	input  wire logic        BATTERY_FAULT,
	input  wire logic        SYSTEM_RAIL_FAULT,
	input  wire logic        DIE_SHUTDOWN,
	input  wire logic [2:0]  THERMISTOR_ZONE,
	input  wire logic        THERMAL_REG,
	input  wire logic        MIN_SYSTEM_REG,
	input  wire logic        INPUT_CURRENT_REG,
	input  wire logic        PIN_CURRENT_LIMIT_REG,
	input  wire logic        INPUT_VOLTAGE_REG,
	input  wire logic        CHARGE_TIMER_EXPIRED,
	input  wire logic        CONV_DONE,
	input  wire logic [15:0] INPUT_CURRENT_SAMPLE,
	input  wire logic [13:0] BATTERY_CURRENT_SAMPLE,
	input  wire logic        BATTERY_CONV_ABORT,
	output logic             CONV_ENABLE,
	output logic             CONV_ONE_SHOT,
	output logic      [1:0]  CONV_SAMPLE_SPEED,
	output logic             RUNNING_AVERAGE_ON,
	output logic             AVERAGE_SEED_SELECT,
	output logic      [7:0]  CHANNEL_OFF,
	output logic             INT_N_OUT,
	output logic             INT_N_OE
);
	import cem_pkg::*;

	// All level inputs come from on-chip logic on this clock
	typedef struct packed {
		logic [7:0]  flag_a;
		logic [7:0]  flag_b;
		logic [7:0]  fault;
		logic [7:0]  mask_a;
		logic [7:0]  mask_b;
		logic [7:0]  fmask;
		logic [7:0]  ctrl;
		logic [7:0]  chan_off;
		logic [15:0] iin;
		logic [15:0] ibat;
		logic [7:0]  prev_a;
		logic [1:0]  prev_phase;
		logic [2:0]  prev_supply;
		logic [2:0]  prev_zone;
		logic [2:0]  prev_f;
		logic        prev_tshut;
		logic        primed;
		logic [7:0]  rdata;
		logic        irq;
	} cem_state_t;

	cem_state_t st_ff;
	cem_state_t nxt_st;

	logic [7:0]  ev_a;
	logic [7:0]  ev_b;
	logic [7:0]  ev_f;
	logic [7:0]  cur_a;
	logic [15:0] iin_clamped;

	always_comb begin
		cur_a = ZERO8;
		cur_a[A_TREG_BIT] = THERMAL_REG;
		cur_a[A_MINSYS_BIT] = MIN_SYSTEM_REG;
		cur_a[A_IINLIM_BIT] = INPUT_CURRENT_REG | PIN_CURRENT_LIMIT_REG;
		cur_a[A_VINLIM_BIT] = INPUT_VOLTAGE_REG;
		cur_a[A_TIMER_BIT] = CHARGE_TIMER_EXPIRED;
		cur_a[A_WDOG_BIT] = WDOG_EXPIRED;
		// Rising edges, except min-system which flags both ways
		ev_a = cur_a & ~st_ff.prev_a;
		ev_a[A_MINSYS_BIT] = cur_a[A_MINSYS_BIT] ^ st_ff.prev_a[A_MINSYS_BIT];
		ev_a[CONV_DONE_BIT] = CONV_DONE & st_ff.ctrl[CONV_RATE_BIT]; // RQ24
		ev_b = ZERO8;
		ev_b[CHG_PHASE_BIT] = st_ff.primed & (CHARGE_PHASE != st_ff.prev_phase); // RQ1
		ev_b[IN_SUPPLY_BIT] = st_ff.primed & (INPUT_SUPPLY_STATUS != st_ff.prev_supply); // RQ2
		ev_f = ZERO8;
		ev_f[F_INOV_BIT] = INPUT_OVERVOLT_SLEEP & ~st_ff.prev_f[2]; // RQ3
		ev_f[F_BAT_BIT] = BATTERY_FAULT & ~st_ff.prev_f[1]; // RQ4
		ev_f[F_SYS_BIT] = SYSTEM_RAIL_FAULT & ~st_ff.prev_f[0]; // RQ5
		ev_f[F_TSHUT_BIT] = DIE_SHUTDOWN & ~st_ff.prev_tshut; // RQ6
		ev_f[F_TZONE_BIT] = st_ff.primed & (THERMISTOR_ZONE != st_ff.prev_zone); // RQ7
	end

	always_comb begin
		// Two's complement clamp of the raw input current sample
		if ($signed(INPUT_CURRENT_SAMPLE) > $signed(IIN_CLAMP_HI)) begin
			iin_clamped = IIN_CLAMP_HI; // RQ22
		end else if ($signed(INPUT_CURRENT_SAMPLE) < $signed(IIN_CLAMP_LO)) begin
			iin_clamped = IIN_CLAMP_LO; // RQ22
		end else begin
			iin_clamped = INPUT_CURRENT_SAMPLE;
		end
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.prev_a = cur_a;
		nxt_st.prev_phase = CHARGE_PHASE;
		nxt_st.prev_supply = INPUT_SUPPLY_STATUS;
		nxt_st.prev_zone = THERMISTOR_ZONE;
		nxt_st.prev_f = {INPUT_OVERVOLT_SLEEP, BATTERY_FAULT, SYSTEM_RAIL_FAULT};
		nxt_st.prev_tshut = DIE_SHUTDOWN;
		nxt_st.primed = 1'b1;

		// Read returns value then clears flags; a new event wins over the clear
		nxt_st.rdata = ZERO8;
		if (REG_RD) begin
			if (REG_ADDR == ADDR_CHARGE_PHASE_CHANGE_LATCH_A) begin
				nxt_st.rdata = st_ff.flag_a;
				nxt_st.flag_a = ZERO8; // RQ26
			end else if (REG_ADDR == ADDR_CHARGE_PHASE_CHANGE_LATCH_B) begin
				nxt_st.rdata = st_ff.flag_b;
				nxt_st.flag_b = ZERO8; // RQ26
			end else if (REG_ADDR == ADDR_FAULT_FLAG) begin
				nxt_st.rdata = st_ff.fault;
				nxt_st.fault = ZERO8; // RQ26
			end else if (REG_ADDR == ADDR_CHARGE_PHASE_IRQ_BLOCK_A) begin
				nxt_st.rdata = st_ff.mask_a;
			end else if (REG_ADDR == ADDR_CHARGE_PHASE_IRQ_BLOCK_B) begin
				nxt_st.rdata = st_ff.mask_b;
			end else if (REG_ADDR == ADDR_FAULT_MASK) begin
				nxt_st.rdata = st_ff.fmask;
			end else if (REG_ADDR == ADDR_CONV_CTRL) begin
				nxt_st.rdata = st_ff.ctrl;
			end else if (REG_ADDR == ADDR_CHAN_OFF) begin
				nxt_st.rdata = st_ff.chan_off;
			end else if (REG_ADDR == ADDR_IIN_LO) begin
				nxt_st.rdata = st_ff.iin[7:0];
			end else if (REG_ADDR == ADDR_IIN_HI) begin
				nxt_st.rdata = st_ff.iin[15:8];
			end else if (REG_ADDR == ADDR_IBAT_LO) begin
				nxt_st.rdata = st_ff.ibat[7:0];
			end else if (REG_ADDR == ADDR_IBAT_HI) begin
				nxt_st.rdata = st_ff.ibat[15:8];
			end
		end

		nxt_st.flag_a = nxt_st.flag_a | ev_a; // RQ26
		nxt_st.flag_b = nxt_st.flag_b | ev_b; // RQ26
		nxt_st.fault = nxt_st.fault | ev_f; // RQ26

		if (REG_WR) begin
			if (REG_ADDR == ADDR_CHARGE_PHASE_IRQ_BLOCK_A) begin
				nxt_st.mask_a = REG_WDATA & MASK_A_WMASK;
			end else if (REG_ADDR == ADDR_CHARGE_PHASE_IRQ_BLOCK_B) begin
				nxt_st.mask_b = REG_WDATA & MASK_B_WMASK;
			end else if (REG_ADDR == ADDR_FAULT_MASK) begin
				nxt_st.fmask = REG_WDATA & FAULT_WMASK;
			end else if (REG_ADDR == ADDR_CONV_CTRL) begin
				nxt_st.ctrl = REG_WDATA & CONV_WMASK; // RQ18 RQ19 RQ20
			end else if (REG_ADDR == ADDR_CHAN_OFF) begin
				nxt_st.chan_off = REG_WDATA; // RQ21
			end
		end

		// Results only update on a completed pass; never cleared afterwards
		if (CONV_DONE && st_ff.ctrl[CONV_EN_BIT]) begin
			if (!st_ff.chan_off[OFF_IIN_BIT]) begin
				nxt_st.iin = {iin_clamped[14:0], 1'b0}; // RQ17 RQ22
			end
			if (!st_ff.chan_off[OFF_IBAT_BIT]) begin
				if (BATTERY_CONV_ABORT) begin
					nxt_st.ibat = IBAT_ABORT; // RQ23
				end else begin
					nxt_st.ibat = {BATTERY_CURRENT_SAMPLE, 2'b00}; // RQ23
				end
			end
		end

		if (WDOG_EXPIRED) begin
			nxt_st.ctrl[CONV_EN_BIT] = 1'b0; // RQ16
		end
		if (REG_RESET) begin
			nxt_st.mask_a = ZERO8; // RQ16
			nxt_st.mask_b = ZERO8;
			nxt_st.fmask = ZERO8;
			nxt_st.ctrl = CONV_RESET;
			nxt_st.chan_off = ZERO8;
		end

		// Newly raised flags, filtered by their masks, drive the pulse
		nxt_st.irq = |(ev_a & ~st_ff.mask_a) // RQ8 RQ9 RQ10 RQ11 RQ12
			| |(ev_b & ~st_ff.mask_b) // RQ13
			| |(ev_f & ~st_ff.fmask); // RQ14 RQ15 RQ25
	end

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			st_ff <= '0;
			st_ff.ctrl <= CONV_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign REG_RDATA = st_ff.rdata;
	assign CONV_ENABLE = st_ff.ctrl[CONV_EN_BIT]; // RQ16
	assign CONV_ONE_SHOT = st_ff.ctrl[CONV_RATE_BIT]; // RQ18
	assign CONV_SAMPLE_SPEED = st_ff.ctrl[CONV_SPEED_HI:CONV_SPEED_LO]; // RQ19
	assign RUNNING_AVERAGE_ON = st_ff.ctrl[CONV_AVG_BIT]; // RQ20
	assign AVERAGE_SEED_SELECT = st_ff.ctrl[CONV_SEED_BIT]; // RQ20
	assign CHANNEL_OFF = st_ff.chan_off;
	// Open drain: drive low only during the one-cycle pulse
	assign INT_N_OUT = 1'b0;
	assign INT_N_OE = st_ff.irq; // RQ25
endmodule

// *** rtl/cem_pkg.sv ***
// Register map, field positions and reset values of the event, mask and converter bank
package cem_pkg;
	localparam logic [7:0] ADDR_CHARGE_PHASE_CHANGE_LATCH_A  = 8'h20;
	localparam logic [7:0] ADDR_CHARGE_PHASE_CHANGE_LATCH_B  = 8'h21;
	localparam logic [7:0] ADDR_FAULT_FLAG  = 8'h22;
	localparam logic [7:0] ADDR_CHARGE_PHASE_IRQ_BLOCK_A  = 8'h23;
	localparam logic [7:0] ADDR_CHARGE_PHASE_IRQ_BLOCK_B  = 8'h24;
	localparam logic [7:0] ADDR_FAULT_MASK  = 8'h25;
	localparam logic [7:0] ADDR_CONV_CTRL   = 8'h26;
	localparam logic [7:0] ADDR_CHAN_OFF    = 8'h27;
	localparam logic [7:0] ADDR_IIN_LO      = 8'h28;
	localparam logic [7:0] ADDR_IIN_HI      = 8'h29;
	localparam logic [7:0] ADDR_IBAT_LO     = 8'h2A;
	localparam logic [7:0] ADDR_IBAT_HI     = 8'h2B;

	localparam logic [7:0] MASK_A_WMASK     = 8'h7F;
	localparam logic [7:0] MASK_B_WMASK     = 8'h09;
	localparam logic [7:0] FAULT_WMASK      = 8'hE9;
	localparam logic [7:0] CONV_WMASK       = 8'hFC;
	localparam logic [7:0] CONV_RESET       = 8'h30;
	localparam logic [7:0] ZERO8            = 8'h00;
	localparam logic [15:0] ZERO16          = 16'h0000;

	localparam int CONV_EN_BIT    = 7;
	localparam int CONV_RATE_BIT  = 6;
	localparam int CONV_DONE_BIT  = 6;
	localparam int CHG_PHASE_BIT  = 3;
	localparam int IN_SUPPLY_BIT  = 0;
	localparam int F_INOV_BIT     = 7;
	localparam int F_BAT_BIT      = 6;
	localparam int F_SYS_BIT      = 5;
	localparam int F_TSHUT_BIT    = 3;
	localparam int F_TZONE_BIT    = 0;
	localparam int CONV_SPEED_HI  = 5;
	localparam int CONV_SPEED_LO  = 4;
	localparam int CONV_AVG_BIT   = 3;
	localparam int CONV_SEED_BIT  = 2;
	localparam int OFF_IIN_BIT    = 7;
	localparam int OFF_IBAT_BIT   = 6;
	localparam int A_TREG_BIT     = 5;
	localparam int A_MINSYS_BIT   = 4;
	localparam int A_IINLIM_BIT   = 3;
	localparam int A_VINLIM_BIT   = 2;
	localparam int A_TIMER_BIT    = 1;
	localparam int A_WDOG_BIT     = 0;

	localparam logic [15:0] IIN_CLAMP_HI  = 16'h07D0;
	localparam logic [15:0] IIN_CLAMP_LO  = 16'hF830;
	localparam logic [15:0] IBAT_ABORT    = 16'h8000;
endpackage

// *** dv/cem_regs_chk.sv ***
// Port assertions of the event, mask and converter bank
`timescale 1ns/1ns
module cem_regs_chk
	import cem_pkg::*;
(
	input wire logic       CORE_CLK,
	input wire logic       RESET,
	input wire logic       REG_RESET,
	input wire logic       WDOG_EXPIRED,
	input wire logic [7:0] REG_ADDR,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic       CONV_ENABLE,
	input wire logic       CONV_ONE_SHOT,
	input wire logic [1:0] CONV_SAMPLE_SPEED,
	input wire logic       RUNNING_AVERAGE_ON,
	input wire logic       AVERAGE_SEED_SELECT,
	input wire logic [7:0] CHANNEL_OFF,
	input wire logic       INT_N_OUT
);
	logic [5:0] ctl;
	assign ctl = {CONV_ENABLE, CONV_ONE_SHOT, CONV_SAMPLE_SPEED, RUNNING_AVERAGE_ON,
		AVERAGE_SEED_SELECT};
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	property p_rd_idle; !REG_RD |=> REG_RDATA == ZERO8; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_unmapped; REG_RD && REG_ADDR == 8'h40 |=> REG_RDATA == ZERO8; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_regrst; REG_RESET |=> ctl == 6'h0C && CHANNEL_OFF == ZERO8; endproperty
	a_regrst: assert property (p_regrst) else $error("register reset");
	property p_wdog; WDOG_EXPIRED |=> !CONV_ENABLE; endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog enable");
	property p_ctrl_wr; REG_WR && REG_ADDR == ADDR_CONV_CTRL && !REG_RESET && !WDOG_EXPIRED
		|=> {2'b00, ctl} == ($past(REG_WDATA) >> 2); endproperty
	a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write");
	property p_chan_wr; REG_WR && REG_ADDR == ADDR_CHAN_OFF && !REG_RESET
		|=> CHANNEL_OFF == $past(REG_WDATA); endproperty
	a_chan_wr: assert property (p_chan_wr) else $error("channel write");
	property p_hold; !REG_WR && !REG_RESET && !WDOG_EXPIRED
		|=> $stable(ctl) && $stable(CHANNEL_OFF); endproperty
	a_hold: assert property (p_hold) else $error("control drift");
	property p_ctrl_rd; REG_RD && REG_ADDR == ADDR_CONV_CTRL
		|=> REG_RDATA == {$past(ctl), 2'b00}; endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read");
	property p_int_lvl; INT_N_OUT == 1'b0; endproperty
	a_int_lvl: assert property (p_int_lvl) else $error("pin level");
endmodule
bind cem_regs cem_regs_chk chk (.CORE_CLK, .RESET, .REG_RESET, .WDOG_EXPIRED, .REG_ADDR,
	.REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .CONV_ENABLE, .CONV_ONE_SHOT,
	.CONV_SAMPLE_SPEED, .RUNNING_AVERAGE_ON, .AVERAGE_SEED_SELECT, .CHANNEL_OFF, .INT_N_OUT);

// *** dv/cem_host.sv ***
// Host model issuing single register reads and writes
`timescale 1ns/1ns
module cem_host (
	input  wire logic       CORE_CLK,
	input  wire logic [7:0] REG_RDATA,
	output logic      [7:0] REG_ADDR,
	output logic            REG_WR,
	output logic            REG_RD,
	output logic      [7:0] REG_WDATA
);
	initial begin
		REG_ADDR = 8'h00;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_WDATA = 8'h00;
	end
	// Released lines turn inverted so a stale value cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_WDATA <= v;
		REG_WR <= 1'b1;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
		REG_ADDR <= ~a;
		REG_WDATA <= ~v;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		REG_ADDR <= ~a;
		#1 v = REG_RDATA;
	endtask
endmodule

// *** dv/tb_charger_event_mask_adc_regs.sv ***
// Self-checking bench of the event, mask and converter bank
`timescale 1ns/1ns
module tb_charger_event_mask_adc_regs;
	import cem_pkg::*;
	logic        CORE_CLK = 1'b0;
	logic        RESET = 1'b1;
	logic        REG_RESET = 1'b0;
	logic [13:0] lv = '0;
	logic        done = 1'b0;
	logic        abort = 1'b0;
	logic [15:0] iin = '0;
	logic [13:0] ibat = '0;
	logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, d;
	logic        REG_WR, REG_RD, oe;
	int          error_cnt, checked, pulses, p0;
	// Row i: event source lv[i], flag address, expected flag byte
	logic [15:0] tbl [14] = '{16'h2108, 16'h2101, 16'h2201, 16'h2280, 16'h2240, 16'h2220,
		16'h2208, 16'h2020, 16'h2010, 16'h2008, 16'h2008, 16'h2004, 16'h2002, 16'h2001};
	always #4 CORE_CLK = ~CORE_CLK;
	always @(posedge CORE_CLK) if (oe === 1'b1) pulses++;
	cem_host h (.CORE_CLK, .REG_RDATA, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA);
	cem_regs dut (.CORE_CLK, .RESET, .REG_RESET, .WDOG_EXPIRED(lv[13]), .REG_ADDR, .REG_WR,
		.REG_RD, .REG_WDATA, .REG_RDATA, .CHARGE_PHASE({1'b0, lv[0]}),
		.INPUT_SUPPLY_STATUS({2'b00, lv[1]}), .THERMISTOR_ZONE({2'b00, lv[2]}),
		.INPUT_OVERVOLT_SLEEP(lv[3]), .BATTERY_FAULT(lv[4]), .SYSTEM_RAIL_FAULT(lv[5]),
		.DIE_SHUTDOWN(lv[6]), .THERMAL_REG(lv[7]), .MIN_SYSTEM_REG(lv[8]),
		.INPUT_CURRENT_REG(lv[9]), .PIN_CURRENT_LIMIT_REG(lv[10]), .INPUT_VOLTAGE_REG(lv[11]),
		.CHARGE_TIMER_EXPIRED(lv[12]), .CONV_DONE(done), .INPUT_CURRENT_SAMPLE(iin),
		.BATTERY_CURRENT_SAMPLE(ibat), .BATTERY_CONV_ABORT(abort), .CONV_ENABLE(),
		.CONV_ONE_SHOT(), .CONV_SAMPLE_SPEED(), .RUNNING_AVERAGE_ON(), .AVERAGE_SEED_SELECT(),
		.CHANNEL_OFF(), .INT_N_OUT(), .INT_N_OE(oe));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		h.rd(a, d);
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
	endtask
	task automatic conv(input logic [15:0] s, input logic [13:0] b, input logic ab);
		@(posedge CORE_CLK);
		iin <= s;
		ibat <= b;
		abort <= ab;
		done <= 1'b1;
		@(posedge CORE_CLK);
		done <= 1'b0;
		abort <= 1'b0;
		repeat (2) @(posedge CORE_CLK);
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#50000;
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		repeat (10) @(posedge CORE_CLK);
		RESET <= 1'b0;
		repeat (3) @(posedge CORE_CLK);
		rdc(ADDR_CONV_CTRL, CONV_RESET);
		for (int m = 0; m < 2; m++) begin
			for (int i = 0; i < 14; i++) begin
				p0 = pulses;
				@(posedge CORE_CLK);
				lv <= 14'h0001 << i;
				repeat (3) @(posedge CORE_CLK);
				chk("pulses", 16'(1 - m), 16'(pulses - p0));
				rdc(tbl[i][15:8], tbl[i][7:0]);
				@(posedge CORE_CLK);
				lv <= '0;
				repeat (3) @(posedge CORE_CLK);
				h.rd(tbl[i][15:8], d);
				rdc(tbl[i][15:8], 8'h00);
			end
			h.wr(ADDR_CHARGE_PHASE_IRQ_BLOCK_A, 8'hFF);
			h.wr(ADDR_CHARGE_PHASE_IRQ_BLOCK_B, 8'hFF);
			h.wr(ADDR_FAULT_MASK, 8'hFF);
		end
		$display("event table done");
		rdc(ADDR_CHARGE_PHASE_IRQ_BLOCK_B, MASK_B_WMASK);
		rdc(ADDR_FAULT_MASK, FAULT_WMASK);
		@(posedge CORE_CLK);
		REG_RESET <= 1'b1;
		@(posedge CORE_CLK);
		REG_RESET <= 1'b0;
		rdc(ADDR_CHARGE_PHASE_IRQ_BLOCK_A, ZERO8);
		h.wr(ADDR_FAULT_FLAG, 8'hFF);
		rdc(ADDR_FAULT_FLAG, ZERO8);
		rdc(8'h40, ZERO8);
		h.wr(ADDR_CONV_CTRL, 8'hFF);
		rdc(ADDR_CONV_CTRL, 8'hFC);
		h.wr(ADDR_CHAN_OFF, 8'h80);
		h.wr(ADDR_CONV_CTRL, 8'hC0);
		p0 = pulses;
		conv(16'h1000, 14'h0005, 1'b0);
		chk("done pulse", 16'h0001, 16'(pulses - p0));
		rdc(ADDR_CHARGE_PHASE_CHANGE_LATCH_A, 8'h40);
		rdc(ADDR_IIN_HI, ZERO8);
		rdc(ADDR_IBAT_LO, 8'h14);
		h.wr(ADDR_CHAN_OFF, ZERO8);
		conv(16'h1000, 14'h0005, 1'b0);
		rdc(ADDR_IIN_LO, 8'hA0);
		rdc(ADDR_IIN_HI, 8'h0F);
		conv(16'hF000, 14'h3FFF, 1'b1);
		rdc(ADDR_IIN_HI, 8'hF0);
		rdc(ADDR_IBAT_HI, 8'h80);
		h.wr(ADDR_CONV_CTRL, 8'h80);
		h.rd(ADDR_CHARGE_PHASE_CHANGE_LATCH_A, d);
		conv(16'h0010, 14'h0001, 1'b0);
		rdc(ADDR_CHARGE_PHASE_CHANGE_LATCH_A, ZERO8);
		h.wr(ADDR_CONV_CTRL, ZERO8);
		conv(16'h0030, 14'h0002, 1'b0);
		rdc(ADDR_IIN_LO, 8'h20);
		$display("converter tests done");
		tally_and_finish;
	end
endmodule
